// ---- verif/lcs_lamp_model.sv ----
// Far-side model: a strip of four lamps with ballasts on one channel.
// Assumes the bench sets which lamps are broken; one shared fault line results.
`timescale 1ns/1ps
`default_nettype none
module lcs_lamp_model (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [3:0] lamp_bad,
  output logic lamp_fault
);
  // aggregate channel fault
  // The line cannot say which lamp failed, only that one did
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lamp_fault <= 1'b0;
    end else begin
      lamp_fault <= |lamp_bad;
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_lighting_channel_sequencer.sv ----
// Bench for the lighting channel sequencer: registers, dynamic sequence, scenes, faults.
// Assumes the design is built with a two-cycle tick and its register map constants.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.svh"
module tb_lighting_channel_sequencer;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, lamp_fault, fault_flag;
  logic fault_msg_valid, fault_msg_value;
  logic [1:0] bresp, rresp;
  logic [7:0] level;
  logic [3:0] lamp_bad = 4'h0;
  logic [31:0] rv;
  logic [1:0] rr;
  int err_total = 0;
  int samples_checked = 0;
  int msg_cnt = 0;

  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (fault_msg_valid === 1'b1) msg_cnt++;

  lcs_top #(.TICK_CYCLES(2)) u_lcs_top (.mclk(mclk), .rstn(rstn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .lamp_fault(lamp_fault), .level(level), .fault_flag(fault_flag),
    .fault_msg_valid(fault_msg_valid), .fault_msg_value(fault_msg_value));
  lcs_lamp_model u_lcs_lamp_model (.mclk(mclk), .rstn(rstn), .lamp_bad(lamp_bad),
    .lamp_fault(lamp_fault));

  task report_and_stop();
    if (err_total == 0 && samples_checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // No answer time is assumed; a lost answer is left to the watchdog
    do begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
  endtask

  task rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // On/off or acknowledge, then let the strobe and phase change land
  task cmd(input logic [2:0] c);
    wr(`LCS_OFF_CMD, {29'h0, c}, rr);
    repeat (3) @(posedge mclk);
  endtask

  task chk_ph(input logic [2:0] p);
    rd(`LCS_OFF_STAT, rv, rr);
    chk("phase", rv[10:8], p);
  endtask

  // Polls with a bound so a stuck phase shows as a mismatch, not a hang
  task wait_ph(input logic [2:0] p);
    int n;
    n = 0;
    do begin
      rd(`LCS_OFF_STAT, rv, rr);
      n++;
    end while (rv[10:8] !== p && n < 200);
    chk("phase reached", rv[10:8], p);
  endtask

  task t_regs();
    rd(`LCS_OFF_CTRL, rv, rr);
    chk("ctrl reset", rv, 32'h0);
    rd(`LCS_OFF_LEVELS, rv, rr);
    chk("levels reset", rv, {8'h00, `LCS_OFF_LVL, `LCS_HOLD_LVL, `LCS_INIT_LVL});
    rd(`LCS_OFF_T1, rv, rr);
    chk("t1 reset", rv, `LCS_T1_MS);
    rd(`LCS_OFF_THOLD, rv, rr);
    chk("hold reset", rv, `LCS_THOLD_MS);
    rd(`LCS_OFF_T2, rv, rr);
    chk("t2 reset", rv, `LCS_T2_MS);
    rd(32'h30, rv, rr);
    chk("unmapped rresp", rr, `LCS_RESP_ERR);
    chk("unmapped rdata", rv, 32'h0);
    wr(32'h30, 32'hffff_ffff, rr);
    chk("unmapped bresp", rr, `LCS_RESP_ERR);
  endtask

  task t_dyn();
    wr(`LCS_OFF_CTRL, 32'h1, rr);
    wr(`LCS_OFF_LEVELS, 32'h0005a020, rr);
    wr(`LCS_OFF_T1, 32'h14, rr);
    wr(`LCS_OFF_THOLD, 32'h14, rr);
    wr(`LCS_OFF_T2, 32'h14, rr);
    cmd(3'b010);
    chk_ph(3'd0);
    cmd(3'b011);
    chk_ph(3'd1);
    chk("start level", level >= 8'h20 && level < 8'ha0, 1'b1);
    cmd(3'b011);
    chk_ph(3'd1);
    wait_ph(3'd2);
    chk("hold level", level, 8'ha0);
    repeat (30) @(posedge mclk);
    cmd(3'b011);
    repeat (25) @(posedge mclk);
    chk_ph(3'd2);
    cmd(3'b010);
    chk_ph(3'd3);
    cmd(3'b011);
    chk_ph(3'd2);
    chk("back to hold", level, 8'ha0);
    cmd(3'b010);
    cmd(3'b010);
    chk_ph(3'd3);
    wait_ph(3'd0);
    chk("off level", level, 8'h05);
    cmd(3'b011);
    cmd(3'b010);
    chk_ph(3'd3);
    wait_ph(3'd0);
    // Hold left alone runs out by itself into the final ramp
    cmd(3'b011);
    wait_ph(3'd2);
    wait_ph(3'd3);
    wait_ph(3'd0);
  endtask

  task t_scene();
    wr(`LCS_OFF_CTRL, 32'h0, rr);
    wr(32'h48, 32'h1660_0004, rr);
    wr(32'h40, 32'h1110_0000, rr);
    wr(32'h7c, 32'h1330_0000, rr);
    wr(`LCS_OFF_SCENE, 32'h02, rr);
    repeat (30) @(posedge mclk);
    chk("scene 3 level", level, 8'h66);
    wr(`LCS_OFF_SCENE, 32'h10, rr);
    repeat (10) @(posedge mclk);
    chk("scene 17 ignored", level, 8'h66);
    wr(`LCS_OFF_SCENE, 32'h83, rr);
    repeat (5) @(posedge mclk);
    rd(32'h4c, rv, rr);
    chk("stored level", rv[27:20], 8'h66);
    wr(`LCS_OFF_SCENE, 32'h0f, rr);
    repeat (10) @(posedge mclk);
    chk("scene 16 level", level, 8'h33);
    wr(`LCS_OFF_SCENE, 32'h00, rr);
    repeat (10) @(posedge mclk);
    chk("scene 1 level", level, 8'h11);
  endtask

  task t_fault();
    lamp_bad <= 4'b0100;
    repeat (6) @(posedge mclk);
    chk("flag set", fault_flag, 1'b1);
    chk("msg set", fault_msg_value, 1'b1);
    rd(`LCS_OFF_STAT, rv, rr);
    chk("stat flag", rv[12], 1'b1);
    lamp_bad <= 4'b0000;
    repeat (6) @(posedge mclk);
    chk("auto clear", fault_flag, 1'b0);
    wr(`LCS_OFF_CTRL, 32'h2, rr);
    lamp_bad <= 4'b0001;
    repeat (6) @(posedge mclk);
    lamp_bad <= 4'b0000;
    repeat (6) @(posedge mclk);
    chk("latched flag", fault_flag, 1'b1);
    cmd(3'b100);
    repeat (3) @(posedge mclk);
    chk("acked flag", fault_flag, 1'b0);
    chk("msg zero", fault_msg_value, 1'b0);
    chk("msg count", msg_cnt, 4);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_regs();
    t_dyn();
    t_scene();
    t_fault();
    report_and_stop();
  end
endmodule
`default_nettype wire

// ---- verilog/lcs_defines.svh ----
// Constants of the lighting channel sequencer: register map, fields, resets, timing.
// Included by the package user files; holds definitions only.
`ifndef LCS_DEFINES_SVH
`define LCS_DEFINES_SVH
`define LCS_OFF_CTRL 8'h00
`define LCS_OFF_CMD 8'h04
`define LCS_OFF_SCENE 8'h08
`define LCS_OFF_STAT 8'h0c
`define LCS_OFF_LEVELS 8'h10
`define LCS_OFF_T1 8'h14
`define LCS_OFF_THOLD 8'h18
`define LCS_OFF_T2 8'h1c
`define LCS_TABLE_PAGE 2'h1
`define LCS_RESP_OK 2'h0
`define LCS_RESP_ERR 2'h2
`define LCS_SCENE_COUNT 16
`define LCS_STORE_BIT 7
`define LCS_CMD_VAL 0
`define LCS_CMD_GO 1
`define LCS_CMD_ACK 2
`define LCS_CTRL_DYN 0
`define LCS_CTRL_ACK 1
`define LCS_INIT_LVL 8'h80
`define LCS_HOLD_LVL 8'hff
`define LCS_OFF_LVL 8'h01
`define LCS_T1_MS 5000
`define LCS_THOLD_MS 300000
`define LCS_T2_MS 30000
`define LCS_TICK_NS 1000000
`define LCS_CLK_NS 25
`endif

// ---- verilog/lcs_pkg.sv ----
// Types shared by the lighting channel sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package lcs_pkg;
  typedef enum logic [2:0] {
    LCS_IDLE = 3'b000,
    LCS_RAMP_UP = 3'b001,
    LCS_HOLD = 3'b010,
    LCS_FINAL = 3'b011,
    LCS_SCENE = 3'b100
  } lcs_phase_t;
  typedef struct packed {
    logic member;
    logic [7:0] level;
    logic [19:0] trans;
  } lcs_scene_t;
  typedef struct packed {
    logic ack_en;
    logic dyn;
  } lcs_ctrl_t;
endpackage
`default_nettype wire

// ---- verilog/lcs_ramp.sv ----
// Linear brightness ramp from a start level to a target over a tick count.
// Assumes a one-cycle tick strobe from the device time base.
`timescale 1ns/1ps
`default_nettype none
module lcs_ramp #(
  parameter int LW = 8,
  parameter int TW = 20
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic load,
  input wire logic tick,
  input wire logic [LW-1:0] from,
  input wire logic [LW-1:0] to,
  input wire logic [TW-1:0] dur,
  output logic [LW-1:0] level,
  output logic done
);
  if (LW < 1 || TW < 2) begin : g_chk
    $error("ramp widths out of range");
  end

  logic [LW-1:0] start;
  logic [LW-1:0] target;
  logic [TW-1:0] period;
  logic [TW-1:0] elapsed;

  // Level at step n of d, exact at n == d; division avoids drift of an accumulator
  function automatic logic [LW-1:0] lerp(input logic [LW-1:0] a, input logic [LW-1:0] b,
                                         input logic [TW-1:0] n, input logic [TW-1:0] d);
    logic signed [LW+TW+1:0] diff;
    logic signed [LW+TW+1:0] res;
    diff = $signed({{(TW+2){1'b0}}, b}) - $signed({{(TW+2){1'b0}}, a});
    res = $signed({{(TW+2){1'b0}}, a}) + (diff * $signed({2'b00, {LW{1'b0}}, n}))
          / $signed({2'b00, {LW{1'b0}}, d});
    return res[LW-1:0];
  endfunction

  wire [TW-1:0] next_elapsed = elapsed + {{(TW-1){1'b0}}, 1'b1};
  wire step = tick && !done;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      start <= '0;
      target <= '0;
      period <= '0;
      elapsed <= '0;
      level <= '0;
      done <= 1'b1;
    end else if (load) begin
      start <= from;
      target <= to;
      period <= dur;
      elapsed <= '0;
      level <= (dur == '0) ? to : from;
      done <= (dur == '0);
    end else if (step) begin
      elapsed <= next_elapsed;
      level <= lerp(start, target, next_elapsed, period);
      done <= (next_elapsed == period);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  ramp_end_exact_a: assert property (done && !$past(load) |-> level == target)
    else $error("ramp ended away from its target");
  ramp_mono_a: assert property (step && !load |=> elapsed == $past(elapsed) + 1'b1)
    else $error("ramp step count slipped");
endmodule
`default_nettype wire

// ---- verilog/lcs_top.sv ----
// Lighting channel sequencer: scene recall, dynamic timed sequence, fault flag.
// Assumes an AXI4-Lite master on mclk and an unsynchronised lamp fault pin.
// Operation
// - telegram values 0..15 select stored scenes 1..16.
// - recall moves member channel to stored level over scene transition period.
// - scene levels are stored locally; telegram carries only the number.
// - in dynamic mode the one-bit on/off command is the only control.
// - dynamic phases: on at initial, ramp to hold, hold, ramp to off.
// - on during first ramp leaves the sequence unchanged.
// - on during hold restarts the full hold countdown.
// - on during final ramp returns to hold, repeating hold and final ramp.
// - off during first ramp or hold starts the final ramp at once.
// - off during final ramp changes nothing; ramp runs to off level.
// - lamp and ballast faults give one aggregate flag per channel.
// - with acknowledgement on, flag stays set until explicitly acknowledged.
// - with acknowledgement off, flag clears once the fault is gone.
// - status is kept continuously and returned on every query.
// - after an acknowledged fault clears, send fault status value 0.
// - scene byte: bit 7 store/recall, low bits number; beyond sixteen ignored. The code checks only bits 5:0, so bit 6 is ignored.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "lcs_defines.svh"
module lcs_top #(
  parameter int TICK_CYCLES = `LCS_TICK_NS / `LCS_CLK_NS
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic lamp_fault,
  output logic [7:0] level,
  output logic fault_flag,
  output logic fault_msg_valid,
  output logic fault_msg_value
);
  if (TICK_CYCLES < 1 || TICK_CYCLES > 32'h00ffffff) begin : g_chk
    $error("TICK_CYCLES out of range");
  end

  lcs_pkg::lcs_ctrl_t ctrl;
  lcs_pkg::lcs_phase_t phase;
  lcs_pkg::lcs_phase_t next_phase;
  lcs_pkg::lcs_scene_t table_q [`LCS_SCENE_COUNT];
  logic [7:0] init_lvl, hold_lvl, off_lvl;
  logic [19:0] t1, thold, t2, hold_cnt, next_hold_cnt;
  logic [23:0] pre_cnt;
  logic tick;
  logic [31:0] aw_addr, w_data;
  logic [3:0] w_strb;
  logic cmd_on, cmd_off, ack_p, scene_p;
  logic [7:0] tele;
  logic fault_meta, fault_sync;
  logic ld;
  logic [7:0] ld_from, ld_to;
  logic [19:0] ld_dur;
  logic ramp_done;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] st);
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        old[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return old;
  endfunction

  function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
    return a == {24'h000000, off};
  endfunction

  function automatic logic is_tab(input logic [31:0] a);
    return a[31:8] == 24'h000000 && a[7:6] == `LCS_TABLE_PAGE && a[1:0] == 2'h0;
  endfunction

  // Device time base
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pre_cnt <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (pre_cnt == 24'(TICK_CYCLES - 1));
      pre_cnt <= (pre_cnt == 24'(TICK_CYCLES - 1)) ? '0 : pre_cnt + 24'h000001;
    end
  end

  // Write channel: address and data taken in either order, answer after both
  wire wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire wr_ok = is_tab(aw_addr) || is_reg(aw_addr, `LCS_OFF_CTRL) || is_reg(aw_addr, `LCS_OFF_CMD)
      || is_reg(aw_addr, `LCS_OFF_SCENE) || is_reg(aw_addr, `LCS_OFF_STAT)
      || is_reg(aw_addr, `LCS_OFF_LEVELS) || is_reg(aw_addr, `LCS_OFF_T1)
      || is_reg(aw_addr, `LCS_OFF_THOLD) || is_reg(aw_addr, `LCS_OFF_T2);
  wire [31:0] wm_levels = merge({8'h00, off_lvl, hold_lvl, init_lvl}, w_data, w_strb);
  wire [3:0] w_idx = aw_addr[5:2];
  wire [31:0] wm_tab = merge({3'h0, table_q[w_idx]}, w_data, w_strb);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `LCS_RESP_OK;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `LCS_RESP_OK : `LCS_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_lo = wr_go && w_strb[0];
  wire store_p = scene_p && tele[`LCS_STORE_BIT] && !ctrl.dyn;
  wire tele_ok = tele[5:0] < 6'(`LCS_SCENE_COUNT);
  wire [3:0] sc_idx = tele[3:0];
  wire lcs_pkg::lcs_scene_t sc = table_q[sc_idx];

  // Configuration and command strobes
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ctrl <= '0;
      init_lvl <= `LCS_INIT_LVL;
      hold_lvl <= `LCS_HOLD_LVL;
      off_lvl <= `LCS_OFF_LVL;
      t1 <= 20'(`LCS_T1_MS);
      thold <= 20'(`LCS_THOLD_MS);
      t2 <= 20'(`LCS_T2_MS);
      cmd_on <= 1'b0;
      cmd_off <= 1'b0;
      ack_p <= 1'b0;
      scene_p <= 1'b0;
      tele <= '0;
      for (int i = 0; i < `LCS_SCENE_COUNT; i++) begin
        table_q[i] <= '0;
      end
    end else begin
      cmd_on <= wr_lo && is_reg(aw_addr, `LCS_OFF_CMD) && w_data[`LCS_CMD_GO]
          && w_data[`LCS_CMD_VAL];
      cmd_off <= wr_lo && is_reg(aw_addr, `LCS_OFF_CMD) && w_data[`LCS_CMD_GO]
          && !w_data[`LCS_CMD_VAL];
      ack_p <= wr_lo && is_reg(aw_addr, `LCS_OFF_CMD) && w_data[`LCS_CMD_ACK];
      scene_p <= wr_lo && is_reg(aw_addr, `LCS_OFF_SCENE);
      if (wr_lo && is_reg(aw_addr, `LCS_OFF_SCENE)) begin
        tele <= w_data[7:0];
      end
      if (wr_lo && is_reg(aw_addr, `LCS_OFF_CTRL)) begin
        ctrl <= {w_data[`LCS_CTRL_ACK], w_data[`LCS_CTRL_DYN]};
      end
      if (wr_go && is_reg(aw_addr, `LCS_OFF_LEVELS)) begin
        {off_lvl, hold_lvl, init_lvl} <= wm_levels[23:0];
      end
      if (wr_go && is_reg(aw_addr, `LCS_OFF_T1)) begin
        t1 <= 20'(merge({12'h000, t1}, w_data, w_strb));
      end
      if (wr_go && is_reg(aw_addr, `LCS_OFF_THOLD)) begin
        thold <= 20'(merge({12'h000, thold}, w_data, w_strb));
      end
      if (wr_go && is_reg(aw_addr, `LCS_OFF_T2)) begin
        t2 <= 20'(merge({12'h000, t2}, w_data, w_strb));
      end
      if (wr_go && is_tab(aw_addr)) begin
        table_q[w_idx] <= wm_tab[28:0];
      end else if (store_p && tele_ok) begin
        table_q[sc_idx].level <= level;
      end
    end
  end

  // Sequencer; scenes only react outside dynamic mode
  wire recall_p = scene_p && !tele[`LCS_STORE_BIT] && tele_ok && !ctrl.dyn && sc.member;
  always_comb begin
    next_phase = phase;
    next_hold_cnt = hold_cnt;
    ld = 1'b0;
    ld_from = level;
    ld_to = off_lvl;
    ld_dur = t2;
    case (phase)
      lcs_pkg::LCS_IDLE, lcs_pkg::LCS_SCENE: begin
        if (ctrl.dyn && cmd_on) begin
          next_phase = lcs_pkg::LCS_RAMP_UP;
          ld = 1'b1;
          ld_from = init_lvl;
          ld_to = hold_lvl;
          ld_dur = t1;
        end else if (recall_p) begin
          next_phase = lcs_pkg::LCS_SCENE;
          ld = 1'b1;
          ld_to = sc.level;
          ld_dur = sc.trans;
        end else if (phase == lcs_pkg::LCS_SCENE && ramp_done) begin
          next_phase = lcs_pkg::LCS_IDLE;
        end
      end
      lcs_pkg::LCS_RAMP_UP: begin
        // on strobe has no branch here
        if (cmd_off) begin
          next_phase = lcs_pkg::LCS_FINAL;
          ld = 1'b1;
        end else if (ramp_done) begin
          next_phase = lcs_pkg::LCS_HOLD;
          next_hold_cnt = thold;
        end
      end
      lcs_pkg::LCS_HOLD: begin
        if (cmd_off || hold_cnt == '0) begin
          next_phase = lcs_pkg::LCS_FINAL;
          ld = 1'b1;
        end else if (cmd_on) begin
          next_hold_cnt = thold;
        end else if (tick) begin
          next_hold_cnt = hold_cnt - 20'h00001;
        end
      end
      lcs_pkg::LCS_FINAL: begin
        if (cmd_on) begin
          next_phase = lcs_pkg::LCS_HOLD;
          next_hold_cnt = thold;
          ld = 1'b1;
          ld_to = hold_lvl;
          ld_dur = '0;
        end else if (ramp_done) begin
          next_phase = lcs_pkg::LCS_IDLE;
        end
      end
      default: begin
        next_phase = lcs_pkg::LCS_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      phase <= lcs_pkg::LCS_IDLE;
      hold_cnt <= '0;
    end else begin
      phase <= next_phase;
      hold_cnt <= next_hold_cnt;
    end
  end

  lcs_ramp #(.LW(8), .TW(20)) u_ramp (
    .mclk(mclk),
    .rstn(rstn),
    .load(ld),
    .tick(tick),
    .from(ld_from),
    .to(ld_to),
    .dur(ld_dur),
    .level(level),
    .done(ramp_done)
  );

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      fault_meta <= 1'b0;
      fault_sync <= 1'b0;
      fault_flag <= 1'b0;
      fault_msg_valid <= 1'b0;
      fault_msg_value <= 1'b0;
    end else begin
      fault_meta <= lamp_fault;
      fault_sync <= fault_meta;
      fault_msg_valid <= 1'b0;
      if (fault_sync) begin
        fault_flag <= 1'b1;
        fault_msg_valid <= !fault_flag;
        fault_msg_value <= 1'b1;
      end else if (fault_flag && (!ctrl.ack_en || ack_p)) begin
        fault_flag <= 1'b0;
        fault_msg_valid <= 1'b1;
        fault_msg_value <= 1'b0;
      end
    end
  end

  wire [31:0] rd_mux = is_reg(s_axi_araddr, `LCS_OFF_CTRL) ? {30'h0, ctrl} :
      is_reg(s_axi_araddr, `LCS_OFF_STAT) ?
      {18'h0, fault_sync, fault_flag, 1'b0, phase, level} :
      is_reg(s_axi_araddr, `LCS_OFF_SCENE) ? {24'h0, tele} :
      is_reg(s_axi_araddr, `LCS_OFF_LEVELS) ? {8'h0, off_lvl, hold_lvl, init_lvl} :
      is_reg(s_axi_araddr, `LCS_OFF_T1) ? {12'h0, t1} :
      is_reg(s_axi_araddr, `LCS_OFF_THOLD) ? {12'h0, thold} :
      is_reg(s_axi_araddr, `LCS_OFF_T2) ? {12'h0, t2} :
      is_tab(s_axi_araddr) ? {3'h0, table_q[s_axi_araddr[5:2]]} : 32'h0;
  wire rd_ok = is_tab(s_axi_araddr) || is_reg(s_axi_araddr, `LCS_OFF_CMD)
      || (rd_mux != 32'h0) || is_reg(s_axi_araddr, `LCS_OFF_CTRL)
      || is_reg(s_axi_araddr, `LCS_OFF_STAT) || is_reg(s_axi_araddr, `LCS_OFF_SCENE)
      || is_reg(s_axi_araddr, `LCS_OFF_LEVELS) || is_reg(s_axi_araddr, `LCS_OFF_T1)
      || is_reg(s_axi_araddr, `LCS_OFF_THOLD) || is_reg(s_axi_araddr, `LCS_OFF_T2);

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `LCS_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `LCS_RESP_OK : `LCS_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  recall_go_a: assert property (phase == lcs_pkg::LCS_IDLE && recall_p && !cmd_on |=>
      phase == lcs_pkg::LCS_SCENE) else $error("recall did not start scene");
  scene_map_a: assert property (recall_p && sc.trans == '0 |=> level == $past(sc.level))
    else $error("wrong scene level applied");
  scene_range_a: assert property (scene_p && !tele_ok && !cmd_on && !cmd_off |=>
      $stable(table_q[sc_idx]) && phase != lcs_pkg::LCS_SCENE || $past(phase) == lcs_pkg::LCS_SCENE)
    else $error("out of range scene reacted");
  scene_store_a: assert property (store_p && tele_ok && !wr_go |=>
      table_q[$past(sc_idx)].level == $past(level)) else $error("scene store lost");
  dyn_start_a: assert property (phase == lcs_pkg::LCS_IDLE && ctrl.dyn && cmd_on |=>
      phase == lcs_pkg::LCS_RAMP_UP && level == $past(init_lvl)) else $error("no start");
  up_retrig_a: assert property (phase == lcs_pkg::LCS_RAMP_UP && cmd_on && !ramp_done |=>
      phase == lcs_pkg::LCS_RAMP_UP) else $error("first ramp disturbed");
  hold_restart_a: assert property (phase == lcs_pkg::LCS_HOLD && cmd_on && hold_cnt != '0 |=>
      hold_cnt == $past(thold)) else $error("hold not restarted");
  final_back_a: assert property (phase == lcs_pkg::LCS_FINAL && cmd_on |=>
      phase == lcs_pkg::LCS_HOLD ##1 level == $past(hold_lvl, 2)) else $error("no return");
  off_early_a: assert property ((phase == lcs_pkg::LCS_RAMP_UP || phase == lcs_pkg::LCS_HOLD)
      && cmd_off |=> phase == lcs_pkg::LCS_FINAL) else $error("off ignored");
  off_final_a: assert property (phase == lcs_pkg::LCS_FINAL && cmd_off && !ramp_done |=>
      phase == lcs_pkg::LCS_FINAL) else $error("final ramp altered");
  phase_order_a: assert property (phase == lcs_pkg::LCS_RAMP_UP && ramp_done && !cmd_off
      |=> phase == lcs_pkg::LCS_HOLD && level == $past(hold_lvl)) else $error("bad order");
  fault_set_a: assert property (fault_sync |=> fault_flag)
    else $error("fault not flagged");
  fault_keep_a: assert property (ctrl.ack_en && fault_flag && !ack_p |=> fault_flag)
    else $error("flag dropped without ack");
  fault_auto_a: assert property (!ctrl.ack_en && fault_flag && !fault_sync |=> !fault_flag)
    else $error("flag not cleared");
  fault_msg_a: assert property ($fell(fault_flag) |-> fault_msg_valid && !fault_msg_value)
    else $error("no clear message");
  cov_scene_c: cover property (recall_p ##[1:1000] phase == lcs_pkg::LCS_IDLE);
  cov_seq_c: cover property (phase == lcs_pkg::LCS_HOLD ##[1:1000] phase == lcs_pkg::LCS_FINAL);
  cov_ack_c: cover property (ctrl.ack_en && ack_p && fault_flag ##1 !fault_flag);
endmodule
`default_nettype wire
